// file: logic/cpms_defs.svh
// Constants for the controller port mode select block
`ifndef CPMS_DEFS_SVH
`define CPMS_DEFS_SVH

// Interface-select strap codes
`define CPMS_MODE_MUX       2'h0
`define CPMS_MODE_NONMUX    2'h1
`define CPMS_MODE_SERIAL    2'h2
`define CPMS_MODE_HW        2'h3

// Positions inside the synchronised pin vector
`define CPMS_SY_AD_LO       0
`define CPMS_SY_SEL_LO      8
`define CPMS_SY_TSTR        10
`define CPMS_SY_INT         11
`define CPMS_SY_TM0         12
`define CPMS_SY_TM1         13
`define CPMS_SY_TM2         14
`define CPMS_SY_RD          15
`define CPMS_SY_W           16

// Shared data bit roles in hardware-strap mode, and bit 2 as clock in serial mode
`define CPMS_AD_RX_TERM     7
`define CPMS_AD_TX_TERM     6
`define CPMS_AD_RX_FRM1     5
`define CPMS_AD_RX_FRM0     4
`define CPMS_AD_TX_SYNC     3
`define CPMS_AD_RX_SYNC     2
`define CPMS_AD_SCLK        2

// APB register byte offsets
`define CPMS_OFS_STATUS     8'h00
`define CPMS_OFS_MASK       8'h04
`define CPMS_OFS_PORT       8'h08

// Status and mask bit positions
`define CPMS_EV_MODE        0
`define CPMS_EV_RESET       1
`define CPMS_EV_CORE        2
`define CPMS_EV_W           3

// Reset values
`define CPMS_MASK_RST       3'h0
`endif

// file: logic/cpms_pkg.sv
// Types for the controller port mode select block
`include "cpms_defs.svh"
package cpms_pkg;

  // Whole state of the block, registered as one word
  typedef struct packed {
    logic [`CPMS_SY_W-1:0] sync1;
    logic [`CPMS_SY_W-1:0] sync2;
    logic [1:0]            mode;
    logic                  mode_vld;
    logic                  tstr_d;
    logic                  sclk_d;
    logic [`CPMS_EV_W-1:0] status;
    logic [`CPMS_EV_W-1:0] mask;
    logic                  irq;
    logic                  int_oe;
    logic                  int_out;
    logic [7:0]            ad_out;
    logic [7:0]            ad_oe;
    logic [7:0]            par_data;
    logic                  rx_term_dis;
    logic                  tx_term_dis;
    logic [1:0]            rx_frm;
    logic                  tx_sync_sel;
    logic                  rx_sync_sel;
    logic                  jit_sel;
    logic [2:0]            tx_mode;
    logic                  sclk;
    logic                  sclk_rise;
    logic                  reg_reset;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
  } cpms_state_t;

endpackage

// file: logic/cpms_top.sv
// Controller port mode select, shared pin steering and interrupt pin
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cpms_defs.svh"

// Behaviour
// [RULE_01] Two-bit strap picks one of four modes
// [RULE_02] Open-drain interrupt pulled low on events
// [RULE_03] Tristate pin rising edge resets configuration
// [RULE_04] Tristate pin high floats every output
// [RULE_05] Code 01 uses pins as data bus
// [RULE_06] Code 00 uses pins as address/data
// [RULE_07] Strap mode bit 7 disables rx termination
// [RULE_08] Strap mode bit 6 disables tx termination
// [RULE_09] Strap mode bits 5,4 set rx framing
// [RULE_10] Strap mode bit 3 picks tx sync function
// [RULE_11] Strap mode bit 2 picks rx sync function
// [RULE_12] Serial mode takes bit 2 as clock
// [RULE_13] Strap mode tx mode from three selects
// [RULE_14] Strap mode interrupt pin selects jitter clock
// [RULE_15] Shared pins driven only in parallel reads
module cpms_top
  import cpms_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  // Strap and control pins
  input  wire logic [1:0]  host_if_select,
  input  wire logic        tristate_reset_pin,
  input  wire logic        tx_op_mode_sel0,
  input  wire logic        tx_op_mode_sel1,
  input  wire logic        tx_op_mode_sel2,
  // Shared address/data pins
  input  wire logic [7:0]  ad_pin_in,
  output logic      [7:0]  ad_pin_out,
  output logic      [7:0]  ad_pin_oe,
  // Interrupt / jitter select pin
  input  wire logic        int_pin_in,
  output logic             int_pin_out,
  output logic             int_pin_oe,
  // Core side
  input  wire logic        host_rd_cycle,
  input  wire logic [7:0]  core_rd_data,
  input  wire logic        core_event,
  output logic      [1:0]  port_mode,
  output logic      [7:0]  par_bus_data,
  output logic             reg_reset,
  output logic             serial_clk,
  output logic             serial_clk_rise,
  // Hardware-strap configuration
  output logic             rx_term_disable,
  output logic             tx_term_disable,
  output logic             rx_framing_sel1,
  output logic             rx_framing_sel0,
  output logic             tx_sync_func_sel,
  output logic             rx_sync_func_sel,
  output logic             jitter_atten_clk_sel0,
  output logic      [2:0]  tx_op_mode
);
  import cpms_pkg::*;

  cpms_state_t st_r;
  cpms_state_t st_nxt;

  // Synchronised pin views, read only from the second stage
  logic [7:0]            ad_s;
  logic [1:0]            sel_s;
  logic                  tstr_s;
  logic                  hw_mode;
  logic                  par_mode;
  logic                  tstr_rise;
  logic [`CPMS_EV_W-1:0] ev_set;
  logic [`CPMS_EV_W-1:0] ev_clr;
  logic                  apb_wr;
  logic [7:0]            ofs;

  assign ad_s      = st_r.sync2[`CPMS_SY_AD_LO +: 8];
  assign sel_s     = st_r.sync2[`CPMS_SY_SEL_LO +: 2];
  assign tstr_s    = st_r.sync2[`CPMS_SY_TSTR];
  assign hw_mode   = (st_r.mode == `CPMS_MODE_HW);
  assign par_mode  = (st_r.mode == `CPMS_MODE_MUX) || (st_r.mode == `CPMS_MODE_NONMUX);
  assign tstr_rise = tstr_s && !st_r.tstr_d;
  assign apb_wr    = psel && penable && st_r.pready && pwrite;
  assign ofs       = paddr[7:0];

  // Next state of the whole block
  always_comb
  begin
    st_nxt = st_r;
    ev_set = '0;
    ev_clr = '0;
    st_nxt.sync1 = {host_rd_cycle, tx_op_mode_sel2, tx_op_mode_sel1, tx_op_mode_sel0,
                    int_pin_in, tristate_reset_pin, host_if_select, ad_pin_in};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.tstr_d = tstr_s;
    // [RULE_01] strap mode decode
    st_nxt.mode     = sel_s;
    st_nxt.mode_vld = 1'b1;
    ev_set[`CPMS_EV_MODE] = st_r.mode_vld && (sel_s != st_r.mode);
    // [RULE_03] register reset on rising edge
    st_nxt.reg_reset = tstr_rise;
    ev_set[`CPMS_EV_RESET] = tstr_rise;
    ev_set[`CPMS_EV_CORE]  = core_event;
    // [RULE_06] capture of shared bus in parallel modes
    st_nxt.par_data = par_mode ? ad_s : 8'h00;
    // [RULE_05] nonmultiplexed and multiplexed reads drive the bus
    st_nxt.ad_out = core_rd_data;
    // [RULE_15] drivers only in parallel reads
    st_nxt.ad_oe = (par_mode && st_r.sync2[`CPMS_SY_RD] && !tstr_s) ? 8'hff : 8'h00;
    // [RULE_12] serial clock on shared bit 2
    st_nxt.sclk      = (st_r.mode == `CPMS_MODE_SERIAL) && ad_s[`CPMS_AD_SCLK];
    st_nxt.sclk_d    = st_r.sclk;
    st_nxt.sclk_rise = st_r.sclk && !st_r.sclk_d;
    // [RULE_07] rx termination strap
    st_nxt.rx_term_dis = hw_mode && ad_s[`CPMS_AD_RX_TERM];
    // [RULE_08] tx termination strap
    st_nxt.tx_term_dis = hw_mode && ad_s[`CPMS_AD_TX_TERM];
    // [RULE_09] rx framing straps
    st_nxt.rx_frm = hw_mode ? {ad_s[`CPMS_AD_RX_FRM1], ad_s[`CPMS_AD_RX_FRM0]} : 2'h0;
    // [RULE_10] tx sync function strap
    st_nxt.tx_sync_sel = hw_mode && ad_s[`CPMS_AD_TX_SYNC];
    // [RULE_11] rx sync function strap
    st_nxt.rx_sync_sel = hw_mode && ad_s[`CPMS_AD_RX_SYNC];
    // [RULE_13] tx mode from three selects
    st_nxt.tx_mode = hw_mode ? {st_r.sync2[`CPMS_SY_TM2], st_r.sync2[`CPMS_SY_TM1],
                                st_r.sync2[`CPMS_SY_TM0]} : 3'h0;
    // [RULE_14] interrupt pin read as jitter select
    st_nxt.jit_sel = hw_mode && st_r.sync2[`CPMS_SY_INT];
    // Write-one-to-clear and mask write
    if (apb_wr && ofs == `CPMS_OFS_STATUS)
    begin
      ev_clr = pwdata[`CPMS_EV_W-1:0];
    end
    if (apb_wr && ofs == `CPMS_OFS_MASK)
    begin
      st_nxt.mask = pwdata[`CPMS_EV_W-1:0];
    end
    if (tstr_rise)
    begin
      st_nxt.mask = `CPMS_MASK_RST;
    end
    // Set wins over clear
    st_nxt.status = (st_r.status & ~ev_clr) | ev_set;
    st_nxt.irq    = |(st_r.status & st_r.mask);
    // [RULE_02] open-drain low while interrupt pending
    st_nxt.int_out = 1'b0;
    // [RULE_04] tristate pin floats the interrupt pin
    st_nxt.int_oe  = st_r.irq && !hw_mode && !tstr_s;
    // APB answer one cycle after setup
    st_nxt.pready  = psel && !penable;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata  = 32'h0000_0000;
    if (psel && !penable)
    begin
      unique case (ofs)
        `CPMS_OFS_STATUS: st_nxt.prdata = {29'h0, st_r.status};
        `CPMS_OFS_MASK:   st_nxt.prdata = {29'h0, st_r.mask};
        `CPMS_OFS_PORT:   st_nxt.prdata = {22'h0, tstr_s, hw_mode, st_r.par_data};
        default:          st_nxt.pslverr = 1'b1;
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign prdata                = st_r.prdata;
  assign pready                = st_r.pready;
  assign pslverr               = st_r.pslverr;
  assign irq                   = st_r.irq;
  assign ad_pin_out            = st_r.ad_out;
  assign ad_pin_oe             = st_r.ad_oe;
  assign int_pin_out           = st_r.int_out;
  assign int_pin_oe            = st_r.int_oe;
  assign port_mode             = st_r.mode;
  assign par_bus_data          = st_r.par_data;
  assign reg_reset             = st_r.reg_reset;
  assign serial_clk            = st_r.sclk;
  assign serial_clk_rise       = st_r.sclk_rise;
  assign rx_term_disable       = st_r.rx_term_dis;
  assign tx_term_disable       = st_r.tx_term_dis;
  assign rx_framing_sel1       = st_r.rx_frm[1];
  assign rx_framing_sel0       = st_r.rx_frm[0];
  assign tx_sync_func_sel      = st_r.tx_sync_sel;
  assign rx_sync_func_sel      = st_r.rx_sync_sel;
  assign jitter_atten_clk_sel0 = st_r.jit_sel;
  assign tx_op_mode            = st_r.tx_mode;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Rising tristate pin leads to reset pulse
  sequence s_tstr_rise;
    $rose(tstr_s);
  endsequence

  a_mode_follow: assert property ($changed(sel_s) |=> port_mode == $past(sel_s)) // RULE_01
    else $error("port mode does not follow strap");
  a_int_drive: assert property (irq && !hw_mode && !tstr_s |=> int_pin_oe && !int_pin_out) // RULE_02
    else $error("interrupt pin not pulled low");
  a_reset_pulse: assert property (s_tstr_rise |=> reg_reset ##1 !reg_reset) // RULE_03
    else $error("missing one-cycle register reset");
  a_reset_mask: assert property (s_tstr_rise |=> st_r.mask == `CPMS_MASK_RST) // RULE_03
    else $error("mask not returned to default");
  a_tstr_float: assert property (tstr_s |=> ad_pin_oe == 8'h00 && !int_pin_oe) // RULE_04
    else $error("pin driven while tristated");
  a_par_capture: assert property (par_mode |=> par_bus_data == $past(ad_s)) // RULE_05
    else $error("parallel bus not captured");
  a_rx_term: assert property (hw_mode |=> rx_term_disable == $past(ad_s[7])) // RULE_07
    else $error("rx termination strap wrong");
  a_tx_term: assert property (hw_mode |=> tx_term_disable == $past(ad_s[6])) // RULE_08
    else $error("tx termination strap wrong");
  a_rx_framing: assert property (hw_mode |=> {rx_framing_sel1, rx_framing_sel0} == $past(ad_s[5:4])) // RULE_09
    else $error("rx framing strap wrong");
  a_sync_sel: assert property (hw_mode |=> tx_sync_func_sel == $past(ad_s[3])
                               && rx_sync_func_sel == $past(ad_s[2])) // RULE_10
    else $error("sync function strap wrong");
  a_sclk_edge: assert property (serial_clk_rise |-> $past(serial_clk) && !$past(serial_clk, 2)) // RULE_12
    else $error("serial clock edge misplaced");
  a_no_drive: assert property (!par_mode |=> ad_pin_oe == 8'h00) // RULE_15
    else $error("shared pins driven outside parallel mode");

endmodule
`default_nettype wire

// file: test/cpms_host_model.sv
// Host and board side of the shared pins and the interrupt line
`timescale 1ns/1ps
`default_nettype none
module cpms_host_model (
  // Device pin drivers
  input  wire logic [7:0] dev_ad_out,
  input  wire logic [7:0] dev_ad_oe,
  input  wire logic       dev_int_oe,
  // Host and board drive values
  input  wire logic [7:0] host_ad,
  input  wire logic       host_ad_en,
  input  wire logic       strap_jit,
  input  wire logic       hw_mode,
  // Resolved pin levels
  output logic      [7:0] ad_wire,
  output logic            int_wire
);
  // Undriven data lines show the inverse so a stale value never passes
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      ad_wire[i] = dev_ad_oe[i] ? dev_ad_out[i] : (host_ad_en ? host_ad[i] : ~dev_ad_out[i]);
  end
  assign int_wire = dev_int_oe ? 1'b0 : (hw_mode ? strap_jit : 1'b1);
endmodule
`default_nettype wire

// file: test/cpms_top_tb.sv
// Self-checking testbench for the controller port mode select block
`timescale 1ns/1ps
`default_nettype none
module cpms_top_tb;
  import cpms_pkg::*;
  logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq, tstr;
  logic [31:0] paddr, pwdata, prdata;
  logic [1:0] sel, port_mode;
  logic [2:0] tsel, tx_op_mode;
  logic [7:0] ad_in, ad_out, ad_oe, core_d, par_d, host_ad;
  logic rd_cyc, ev, int_in, int_out, int_oe, rr, sclk, sclk_r, hen, jit;
  logic [6:0] strap;
  logic [32:0] exp_q[$];
  int err_total, checks_done, rr_cnt, seed;
  cpms_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .host_if_select(sel), .tristate_reset_pin(tstr),
    .tx_op_mode_sel0(tsel[0]), .tx_op_mode_sel1(tsel[1]), .tx_op_mode_sel2(tsel[2]),
    .ad_pin_in(ad_in), .ad_pin_out(ad_out), .ad_pin_oe(ad_oe), .int_pin_in(int_in),
    .int_pin_out(int_out), .int_pin_oe(int_oe), .host_rd_cycle(rd_cyc),
    .core_rd_data(core_d), .core_event(ev), .port_mode(port_mode), .par_bus_data(par_d),
    .reg_reset(rr), .serial_clk(sclk), .serial_clk_rise(sclk_r),
    .rx_term_disable(strap[6]), .tx_term_disable(strap[5]), .rx_framing_sel1(strap[4]),
    .rx_framing_sel0(strap[3]), .tx_sync_func_sel(strap[2]), .rx_sync_func_sel(strap[1]),
    .jitter_atten_clk_sel0(strap[0]), .tx_op_mode(tx_op_mode));
  cpms_host_model host (.dev_ad_out(ad_out), .dev_ad_oe(ad_oe), .dev_int_oe(int_oe),
    .host_ad(host_ad), .host_ad_en(hen), .strap_jit(jit), .hw_mode(sel == 2'h3),
    .ad_wire(ad_in), .int_wire(int_in));
  // Clock generation
  initial
  begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Compare one value against its expectation
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Print counts and verdict, then stop
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One APB transfer; reads note {pslverr, prdata} expected
  task automatic apb(input logic wr, input logic [7:0] a, input logic [32:0] e);
    int n;
    n = 0;
    // Let an edge pass so the strobe never changes twice in one step
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= {24'h0, a};
    pwdata <= e[31:0];
    if (!wr)
      exp_q.push_back(e);
    @(posedge sys_clk);
    penable <= 1;
    // Hold the request until pready is seen high at a rising edge
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      err_total++;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Read monitor takes the oldest note when a read completes
  always @(posedge sys_clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      chk({pslverr, prdata}, exp_q.pop_front());
    if (rr === 1'b1)
      rr_cnt++;
  end
  // Watchdog
  initial
  begin
    #200000;
    err_total++;
    final_report();
  end
  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, tstr, rd_cyc, ev} = 6'h00;
    paddr = 32'h0;
    pwdata = 32'h0;
    tsel = 3'h0;
    {core_d, host_ad, hen, jit, err_total, checks_done, rr_cnt} = 0;
    sel = 2'h1;
    seed = 32'h5779f22f;
    cyc(5);
    sys_rst <= 0;
    cyc(6);
    apb(1, 8'h00, 33'h7);
    apb(0, 8'h04, 33'h0);
    apb(1, 8'h04, 33'h7);
    apb(0, 8'h04, 33'h7);
    apb(0, 8'h0c, 33'h100000000);
    // Event raises irq and pulls the pin low until cleared
    ev <= 1;
    cyc(1);
    ev <= 0;
    cyc(4);
    chk({irq, int_oe, int_in}, 3'b110);
    apb(0, 8'h00, 33'h4);
    apb(1, 8'h00, 33'h4);
    cyc(3);
    chk({irq, int_oe, int_in}, 3'b001);
    apb(1, 8'h04, 33'h3);
    ev <= 1;
    cyc(1);
    ev <= 0;
    cyc(4);
    chk(irq, 0);
    apb(1, 8'h00, 33'h7);
    // Every mode: steering, straps, pin drive
    for (int m = 0; m < 4; m++)
    begin
      sel <= m[1:0];
      hen <= 1;
      rd_cyc <= 0;
      host_ad <= 8'($random(seed));
      tsel <= 3'($random(seed));
      jit <= 1'($random(seed));
      core_d <= 8'($random(seed));
      // Jitter select waits for the interrupt driver to let go, then two syncs
      cyc(9);
      chk(port_mode, m);
      chk(par_d, m < 2 ? host_ad : 8'h0);
      chk(strap, m == 3 ? {host_ad[7:2], jit} : 7'h0);
      chk(tx_op_mode, m == 3 ? tsel : 3'h0);
      if (m == 2)
        chk(sclk, host_ad[2]);
      hen <= 0;
      rd_cyc <= 1;
      cyc(5);
      chk(ad_oe, m < 2 ? 8'hff : 8'h0);
      if (m < 2)
        chk(ad_out, core_d);
    end
    // Tristate pin floats outputs and resets configuration
    sel <= 2'h1;
    hen <= 1;
    cyc(6);
    apb(1, 8'h04, 33'h7);
    ev <= 1;
    cyc(1);
    ev <= 0;
    rr_cnt = 0;
    tstr <= 1;
    cyc(8);
    chk({ad_oe, int_oe}, 9'h0);
    chk(rr_cnt, 1);
    tstr <= 0;
    cyc(4);
    apb(0, 8'h04, 33'h0);
    cyc(2);
    final_report();
  end
endmodule
`default_nettype wire
